// ===== nsm_defines.vh
`ifndef NSM_DEFINES_VH
`define NSM_DEFINES_VH

// Register byte offsets in configuration space.
`define NSM_OFF_MSI_CONTROL     12'h064
`define NSM_OFF_MSI_LOWER_ADDR  12'h068
`define NSM_OFF_MSI_UPPER_ADDR  12'h06c
`define NSM_OFF_MSI_PAYLOAD     12'h070
`define NSM_OFF_BRIDGE_CAP_HDR  12'h074
`define NSM_OFF_SIDE_CONTROL    12'h078

// Interrupt capability control fields.
`define NSM_MSI_CAP_ID          8'h05
`define NSM_MSI_NEXT_PTR        8'h74
`define NSM_MSI_ENABLE_BIT      16
`define NSM_MSI_WIDE_BIT        23

// Bridge capability header reset values.
`define NSM_CAP_ID_RESET        8'h09
`define NSM_CAP_NEXT_RESET      8'hb4
`define NSM_CAP_LENGTH_RESET    8'h40
`define NSM_CAP_TYPE_RESET      8'h01

// Far side mode codes.
`define NSM_MODE_ENABLED        2'h0
`define NSM_MODE_NOT_READY      2'h1
`define NSM_MODE_DISABLED       2'h2
`define NSM_MODE_RESERVED       2'h3

`endif

// ===== nsm_rx_gate.v
`timescale 1ns/100ps
`include "nsm_defines.vh"

module nsm_rx_gate (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] farSideMode,
    input  wire       rxValid,
    input  wire       rxIsConfig,
    output reg        rxForward,
    output reg        rxRetry,
    output reg        rxDiscard,
    output reg        rxCreditReturn
);

    wire notReady = (farSideMode == `NSM_MODE_NOT_READY);
    wire disabled = (farSideMode == `NSM_MODE_DISABLED);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxForward      <= 1'b0;
            rxRetry        <= 1'b0;
            rxDiscard      <= 1'b0;
            rxCreditReturn <= 1'b0;
        end else begin
            rxForward      <= rxValid & ~notReady & ~disabled;
            rxRetry        <= rxValid & notReady & rxIsConfig; // RQ10
            rxDiscard      <= rxValid & (disabled | (notReady & ~rxIsConfig)); // RQ10 RQ11
            // Credits flow back for every blocked packet; the link layers never stop.
            rxCreditReturn <= rxValid & (notReady | disabled); // RQ12 RQ13
        end
    end

endmodule // nsm_rx_gate

// ===== nsm_side_mode_regs.v
// Behaviour
// (RQ1) Lower interrupt address held in bits 31:2; bits 1:0 read zero.
// (RQ2) Interrupt write uses 64-bit address when upper address is non-zero.
// (RQ3) Sixteen-bit payload sent as low data bits; bits 31:16 read zero.
// (RQ4) Capability identifier in bits 7:0 resets to 0x9, writable for test.
// (RQ5) Writable next capability pointer in bits 15:8 resets to 0xB4.
// (RQ6) Capability byte length in bits 23:16 resets to 0x40.
// (RQ7) Vendor capability type in bits 31:24 resets to 0x1.
// (RQ8) Host writes the capability header only for testing.
// (RQ9) Far side mode: 0 enabled, 1 not ready, 2 disabled, 3 reserved.
// (RQ10) Not ready: config requests get retry status, others are ignored.
// (RQ11) Disabled: far side traffic discarded, this side still forwards onward.
// (RQ12) Discarded packets still return flow control credits.
// (RQ13) Physical and link layers run whatever the mode.
// (RQ14) When both sides get blocked, the first blocked side reverts to enabled; a mode 1 or 2 write to it in the peer's blocking cycle stops the revert.
// (RQ15) Interrupts are sent only while enable bit 16 is set.
// (RQ16) Read-only bit 23 reads one, advertising 64-bit interrupt addresses.
// (RQ17) Upper 16 payload bits are zero; a single message vector is used.
`timescale 1ns/100ps
`include "nsm_defines.vh"

module nsm_side_mode_regs #(
    parameter INTERNAL_SIDE = 1
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        cfgWrite,
    input  wire        cfgRead,
    input  wire [11:0] cfgAddr,
    input  wire [3:0]  cfgByteEn,
    input  wire [31:0] cfgWriteData,
    output reg  [31:0] cfgReadData,
    output reg         cfgReadValid,
    input  wire [1:0]  peerMode,
    output reg         peerRevert,
    output reg  [1:0]  farSideModeOut,
    input  wire        msiRequest,
    output reg         msiWriteValid,
    output reg         msiWide,
    output reg  [63:0] msiAddress,
    output reg  [31:0] msiData,
    input  wire        rxValid,
    input  wire        rxIsConfig,
    output wire        rxForward,
    output wire        rxRetry,
    output wire        rxDiscard,
    output wire        rxCreditReturn
);

    // The internal side leaves reset with its far side not ready, so the far host
    // cannot reach the bridge until this side releases it.
    localparam [1:0] MODE_RESET = (INTERNAL_SIDE != 0) ? `NSM_MODE_NOT_READY : `NSM_MODE_ENABLED;

    reg        msiEnable;
    reg [29:0] lowerMsgAddressField;
    reg [31:0] upperMsgAddress;
    reg [15:0] msgPayloadValue;
    reg [31:0] capHeader;
    reg [1:0]  farSideMode;
    reg        peerBlockedQ;

    wire peerBlocked = (peerMode == `NSM_MODE_NOT_READY) || (peerMode == `NSM_MODE_DISABLED);

    // Byte-lane merge of a write into a stored word.
    function [31:0] merge;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  lanes;
        integer i;
        begin
            merge = oldWord;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    merge[i*8 +: 8] = newWord[i*8 +: 8];
                end
            end
        end
    endfunction

    function blocking;
        input [1:0] mode;
        begin
            blocking = (mode == `NSM_MODE_NOT_READY) || (mode == `NSM_MODE_DISABLED);
        end
    endfunction

    // A mode write needs the lowest byte lane; the control bits above it are not kept.
    wire writeMsiCtl  = cfgWrite && (cfgAddr == `NSM_OFF_MSI_CONTROL);
    wire writeLower   = cfgWrite && (cfgAddr == `NSM_OFF_MSI_LOWER_ADDR);
    wire writeUpper   = cfgWrite && (cfgAddr == `NSM_OFF_MSI_UPPER_ADDR);
    wire writePayload = cfgWrite && (cfgAddr == `NSM_OFF_MSI_PAYLOAD);
    wire writeCapHdr  = cfgWrite && (cfgAddr == `NSM_OFF_BRIDGE_CAP_HDR);
    wire writeCtl     = cfgWrite && (cfgAddr == `NSM_OFF_SIDE_CONTROL) && cfgByteEn[0];

    // Reserved bits are sliced off the merged word before it is stored, so no write can set them.
    wire [31:0] lowerMerged   = merge({lowerMsgAddressField, 2'b00}, cfgWriteData, cfgByteEn);
    wire [31:0] payloadMerged = merge({16'h0000, msgPayloadValue}, cfgWriteData, cfgByteEn);
    wire [1:0]  writtenMode   = cfgWriteData[1:0];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msiEnable            <= 1'b0;
            lowerMsgAddressField <= 30'h00000000;
            upperMsgAddress      <= 32'h00000000;
            msgPayloadValue      <= 16'h0000;
            capHeader            <= {`NSM_CAP_TYPE_RESET, `NSM_CAP_LENGTH_RESET,
                                     `NSM_CAP_NEXT_RESET, `NSM_CAP_ID_RESET}; // RQ4 RQ5 RQ6 RQ7
        end else begin
            if (writeMsiCtl && cfgByteEn[2]) begin
                msiEnable <= cfgWriteData[`NSM_MSI_ENABLE_BIT]; // RQ15
            end
            if (writeLower) begin
                lowerMsgAddressField <= lowerMerged[31:2]; // RQ1
            end
            if (writeUpper) begin
                upperMsgAddress <= merge(upperMsgAddress, cfgWriteData, cfgByteEn); // RQ2
            end
            if (writePayload) begin
                msgPayloadValue <= payloadMerged[15:0]; // RQ3
            end
            // Test-only writes are honoured in full.
            if (writeCapHdr) begin
                capHeader <= merge(capHeader, cfgWriteData, cfgByteEn); // RQ4 RQ5 RQ6 RQ7 RQ8
            end
        end
    end

    // The far side mode, with the deadlock breaker between the two sides.
    // Only a rising edge of the peer's blocked state reverts this side, so the side
    // that was blocked first returns to enabled unless a mode write of 1 or 2 lands on that edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            farSideMode  <= MODE_RESET;
            peerRevert   <= 1'b0;
            peerBlockedQ <= 1'b0;
        end else begin
            peerBlockedQ <= peerBlocked;
            peerRevert   <= 1'b0;
            if (writeCtl && writtenMode != `NSM_MODE_RESERVED) begin
                farSideMode <= writtenMode; // RQ9
                if (blocking(writtenMode) && peerBlocked && !blocking(farSideMode)) begin
                    peerRevert <= 1'b1; // RQ14
                end
            end else if (blocking(farSideMode) && peerBlocked && !peerBlockedQ) begin
                farSideMode <= `NSM_MODE_ENABLED; // RQ14
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            farSideModeOut <= MODE_RESET;
        end else begin
            farSideModeOut <= farSideMode;
        end
    end

    // Interrupt message generation.
    // Address, width and data hold after a message until the next one is sent.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msiWriteValid <= 1'b0;
            msiWide       <= 1'b0;
            msiAddress    <= 64'h0000000000000000;
            msiData       <= 32'h00000000;
        end else begin
            msiWriteValid <= msiRequest && msiEnable; // RQ15
            if (msiRequest && msiEnable) begin
                msiWide <= (upperMsgAddress != 32'h00000000); // RQ2
                msiAddress <= {upperMsgAddress, lowerMsgAddressField, 2'b00}; // RQ1 RQ2
                msiData <= {16'h0000, msgPayloadValue}; // RQ3 RQ17
            end
        end
    end

    // Read path; unmapped offsets read zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgReadData  <= 32'h00000000;
            cfgReadValid <= 1'b0;
        end else begin
            cfgReadValid <= cfgRead;
            if (cfgRead) begin
                case (cfgAddr)
                    `NSM_OFF_MSI_CONTROL: begin
                        cfgReadData <= {8'h00, 1'b1, 6'h00, msiEnable,
                                        `NSM_MSI_NEXT_PTR, `NSM_MSI_CAP_ID}; // RQ16 RQ17
                    end
                    `NSM_OFF_MSI_LOWER_ADDR: begin
                        cfgReadData <= {lowerMsgAddressField, 2'b00}; // RQ1
                    end
                    `NSM_OFF_MSI_UPPER_ADDR: begin
                        cfgReadData <= upperMsgAddress;
                    end
                    `NSM_OFF_MSI_PAYLOAD: begin
                        cfgReadData <= {16'h0000, msgPayloadValue}; // RQ3
                    end
                    `NSM_OFF_BRIDGE_CAP_HDR: begin
                        cfgReadData <= capHeader;
                    end
                    // Control bits above the mode field are not implemented and read zero.
                    `NSM_OFF_SIDE_CONTROL: begin
                        cfgReadData <= {30'h00000000, farSideMode};
                    end
                    default: begin
                        cfgReadData <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    nsm_rx_gate u_rx_gate (
        .clk            (clk),
        .rst_n          (rst_n),
        .farSideMode    (farSideMode),
        .rxValid        (rxValid),
        .rxIsConfig     (rxIsConfig),
        .rxForward      (rxForward),
        .rxRetry        (rxRetry),
        .rxDiscard      (rxDiscard),
        .rxCreditReturn (rxCreditReturn)
    );

endmodule // nsm_side_mode_regs

// ===== nsm_side_mode_regs_assertions.sv
`timescale 1ns/100ps
module nsm_side_mode_regs_assertions (
    input wire        clk,
    input wire        rst_n,
    input wire        peerRevert,
    input wire [1:0]  farSideModeOut,
    input wire        msiRequest,
    input wire        msiWriteValid,
    input wire        msiWide,
    input wire [63:0] msiAddress,
    input wire [31:0] msiData,
    input wire        rxValid,
    input wire        rxIsConfig,
    input wire        rxForward,
    input wire        rxRetry,
    input wire        rxDiscard,
    input wire        rxCreditReturn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_MSI_CAUSE: assert property (msiWriteValid |-> $past(msiRequest)) else $error("message without request");
    AST_MSI_WIDE: assert property (msiWriteValid |-> msiWide == (msiAddress[63:32] != 32'h0)) else $error("width");
    AST_MSI_ALIGN: assert property (msiWriteValid |-> msiAddress[1:0] == 2'h0) else $error("address low bits");
    AST_MSI_DATA: assert property (msiWriteValid |-> msiData[31:16] == 16'h0) else $error("data high bits");
    AST_RX_CREDIT: assert property (rxValid |=> rxCreditReturn == (rxRetry || rxDiscard)) else $error("credit");
    AST_RX_RETRY: assert property (rxRetry |-> $past(rxValid) && $past(rxIsConfig)) else $error("retry cause");
    AST_RX_ONE: assert property (rxValid |=> $onehot({rxForward, rxRetry, rxDiscard})) else $error("rx result");
    AST_MODE_CODE: assert property (farSideModeOut != 2'h3) else $error("reserved mode held");
    AST_REVERT_PULSE: assert property (peerRevert |=> !peerRevert) else $error("revert too long");
endmodule // nsm_side_mode_regs_assertions

bind nsm_side_mode_regs nsm_side_mode_regs_assertions i_chk (
    .clk(clk), .rst_n(rst_n), .peerRevert(peerRevert), .farSideModeOut(farSideModeOut),
    .msiRequest(msiRequest), .msiWriteValid(msiWriteValid), .msiWide(msiWide), .msiAddress(msiAddress),
    .msiData(msiData), .rxValid(rxValid), .rxIsConfig(rxIsConfig), .rxForward(rxForward),
    .rxRetry(rxRetry), .rxDiscard(rxDiscard), .rxCreditReturn(rxCreditReturn));

// ===== nsm_peer_model.sv
`timescale 1ns/100ps
module nsm_peer_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] setMode,
    input  wire       setValid,
    input  wire       peerRevert,
    output reg  [1:0] peerMode
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peerMode <= 2'h0;
        end else if (setValid && setMode != 2'h3) begin
            peerMode <= setMode;
        end else if (peerRevert) begin
            peerMode <= 2'h0;
        end
    end
endmodule // nsm_peer_model

// ===== ntb_msi_side_mode_regs_tb_top.sv
`timescale 1ns/100ps
module ntb_msi_side_mode_regs_tb_top;
    reg         clk = 1'b0, rst_n = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, setValid = 1'b0;
    reg         msiRequest = 1'b0, rxValid = 1'b0, rxIsConfig = 1'b0;
    reg  [11:0] cfgAddr = 12'h000;
    reg  [3:0]  cfgByteEn = 4'h0;
    reg  [31:0] cfgWriteData = 32'h0, lo, up, pay;
    reg  [1:0]  setMode = 2'h0;
    wire [31:0] cfgReadData, msiData;
    wire [63:0] msiAddress;
    wire [1:0]  peerMode, farSideModeOut;
    wire        cfgReadValid, peerRevert, msiWriteValid, msiWide, rxForward, rxRetry, rxDiscard, rxCreditReturn;
    integer     errors = 0, n_compared = 0, seed = 32'hf23fce6b, i, cur;
    always #4 clk = ~clk;
    nsm_side_mode_regs i_nsm_side_mode_regs (.clk(clk), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
        .cfgReadValid(cfgReadValid), .peerMode(peerMode), .peerRevert(peerRevert), .farSideModeOut(farSideModeOut),
        .msiRequest(msiRequest), .msiWriteValid(msiWriteValid), .msiWide(msiWide), .msiAddress(msiAddress),
        .msiData(msiData), .rxValid(rxValid), .rxIsConfig(rxIsConfig), .rxForward(rxForward), .rxRetry(rxRetry),
        .rxDiscard(rxDiscard), .rxCreditReturn(rxCreditReturn));
    nsm_peer_model i_nsm_peer_model (.clk(clk), .rst_n(rst_n), .setMode(setMode), .setValid(setValid),
        .peerRevert(peerRevert), .peerMode(peerMode));
    task cyc;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task chk(input [99:0] seen, input [99:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input [3:0] be);
        begin
            {cfgWrite, cfgAddr, cfgWriteData, cfgByteEn} = {1'b1, a, d, be};
            cyc;
            cfgWrite = 1'b0;
            cyc;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            {cfgRead, cfgAddr} = {1'b1, a};
            cyc;
            chk({cfgReadValid, cfgReadData}, {1'b1, e});
            cfgRead = 1'b0;
            cyc;
        end
    endtask
    task rx(input c, input [3:0] e);
        begin
            {rxValid, rxIsConfig} = {1'b1, c};
            cyc;
            chk({rxForward, rxRetry, rxDiscard, rxCreditReturn}, e);
            rxValid = 1'b0;
            cyc;
        end
    endtask
    task msi(input e);
        begin
            msiRequest = 1'b1;
            cyc;
            if (e) chk({msiWriteValid, msiWide, msiAddress, msiData}, {1'b1, up != 0, up, lo[31:2], 2'h0, 16'h0, pay[15:0]});
            else chk(msiWriteValid, 1'b0);
            msiRequest = 1'b0;
            cyc;
        end
    endtask
    function [3:0] rxexp(input [1:0] md, input c);
        rxexp = (md == 2'h0) ? 4'h8 : (md == 2'h1 && c) ? 4'h5 : 4'h3;
    endfunction
    task report_and_stop;
        begin
            $display("errors=%0d compared=%0d", errors, n_compared);
            if (errors == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        errors = errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        {lo, up, pay} = {$random(seed), 32'h0, $random(seed)};
        rd(12'h064, 32'h00807405);
        rd(12'h068, 32'h0);
        rd(12'h070, 32'h0);
        rd(12'h074, 32'h0140b409);
        rd(12'h078, 32'h1);
        chk(farSideModeOut, 2'h1);
        msi(1'b0);
        wr(12'h068, lo, 4'hf);
        wr(12'h070, pay, 4'hf);
        rd(12'h068, lo & 32'hfffffffc);
        rd(12'h070, {16'h0, pay[15:0]});
        wr(12'h064, 32'hffffffff, 4'h4);
        rd(12'h064, 32'h00817405);
        msi(1'b1);
        up = $random(seed) | 32'h1;
        wr(12'h06c, up, 4'hf);
        rd(12'h06c, up);
        msi(1'b1);
        wr(12'h074, lo, 4'hf);
        rd(12'h074, lo);
        wr(12'h068, 32'h0, 4'h1);
        rd(12'h068, lo & 32'hffffff00);
        cur = 1;
        for (i = 0; i < 4; i = i + 1) begin
            wr(12'h078, i, 4'h1);
            if (i != 3) cur = i;
            rd(12'h078, cur);
            chk(farSideModeOut, cur[1:0]);
            rx(1'b0, rxexp(cur, 1'b0));
            rx(1'b1, rxexp(cur, 1'b1));
        end
        {setMode, setValid} = {2'h1, 1'b1};
        cyc;
        setValid = 1'b0;
        repeat (3) cyc;
        rd(12'h078, 32'h0);
        chk(farSideModeOut, 2'h0);
        wr(12'h078, 32'h2, 4'h2);
        rd(12'h078, 32'h0);
        {cfgWrite, cfgAddr, cfgWriteData, cfgByteEn} = {1'b1, 12'h078, 32'h2, 4'h1};
        cyc;
        chk(peerRevert, 1'b1);
        cfgWrite = 1'b0;
        cyc;
        chk(peerRevert, 1'b0);
        repeat (2) cyc;
        chk(peerMode, 2'h0);
        for (i = 0; i < 20; i = i + 1) rx($random(seed), 4'h3);
        wr(12'h064, 32'h0, 4'h4);
        msi(1'b0);
        report_and_stop;
    end
endmodule // ntb_msi_side_mode_regs_tb_top
